// >>> inc/llpc_pkg.sv
package llpc_pkg;
   localparam int         CNT_W        = 12;
   localparam logic [4:0] ADDR_CR0     = 5'h00;
   localparam logic [4:0] ADDR_CR1     = 5'h01;
   localparam logic [4:0] ADDR_CR2     = 5'h02;
   localparam logic [4:0] ADDR_STAT    = 5'h07;
   localparam logic [4:0] ADDR_STEP    = 5'h01;
   localparam logic [7:0] RD_NONE      = 8'h00;
   // field positions, bit 0 sits on data line 0
   localparam int         CR0_MODE_LO  = 6;
   localparam int         CR0_CAPT     = 5;
   localparam int         CR0_SLICE_LO = 3;
   localparam int         CR0_OSC_LO   = 0;
   localparam int         CR1_ILACE    = 7;
   localparam int         CR1_CLK_DIS  = 6;
   localparam int         CR1_CS_DIS   = 5;
   localparam int         CR1_FS_DIS   = 4;
   localparam int         CR1_LS_DIS   = 3;
   localparam int         CR1_LL_CLR   = 2;
   localparam int         CR1_CMP_SEL  = 1;
   localparam int         CR1_PLIM     = 0;
   localparam int         CR2_TOL_LO   = 4;
   localparam int         CR2_MASK     = 3;
   localparam int         CR2_OVR      = 2;
   localparam int         CR2_SRC_LO   = 0;
   localparam int         STAT_LLS     = 0;
   localparam int         STAT_SEC     = 5;
   localparam logic       LOCK_RST     = 1'b1;
   // divider phase lengths in oscillator edges
   localparam logic [3:0] OSC_LOW_CNT  = 4'h2;
   localparam logic [3:0] OSC_HIGH_CNT = 4'h2;
   localparam logic [2:0] OSC_A        = 3'h0;
   localparam logic [2:0] OSC_A_N      = 3'h1;
   localparam logic [2:0] OSC_B        = 3'h2;
   localparam logic [2:0] OSC_B_N      = 3'h3;
   localparam logic [2:0] OSC_DIFF_A   = 3'h4;
   localparam logic [2:0] OSC_DIFF_B   = 3'h5;
   typedef enum logic [1:0] {
      MODE_RSV  = 2'b00,
      MODE_SYNC = 2'b01,
      MODE_DIVN = 2'b10,
      MODE_BOTH = 2'b11
   } llpc_mode_type;
   typedef enum logic [1:0] {
      SRC_OSC    = 2'b00,
      SRC_EXT    = 2'b01,
      SRC_DIRECT = 2'b10,
      SRC_RSV    = 2'b11
   } llpc_src_type;
   typedef enum logic [1:0] {
      PD_IDLE = 2'b00,
      PD_REF  = 2'b01,
      PD_CMP  = 2'b10
   } llpc_pd_type;
endpackage : llpc_pkg

// >>> inc/llpc_link_if.sv
`timescale 1ns/100ps
interface llpc_link_if;
   logic       osc_lvl;
   logic       ext_lvl;
   logic       use_ext;
   logic       direct;
   logic       restart;
   logic       stop;
   logic       pclk;
   logic       pix_rise;
   logic       sync_fall;
   logic       cmp_edge;
   logic       line_end;
   logic [3:0] tol;
   logic       limit;
   logic       lost;
   logic       good;
   logic       adj_en;
   modport gen (input osc_lvl, ext_lvl, use_ext, direct, restart, stop,
                output pclk, pix_rise);
   modport phs (input sync_fall, cmp_edge, pix_rise, line_end, tol, limit,
                output lost, good, adj_en);
endinterface : llpc_link_if

// >>> rtl/llpc_pixclk_gen.sv
`timescale 1ns/100ps
module llpc_pixclk_gen (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   llpc_link_if.gen  lk
);
   logic       osc_q;
   logic       pclk_q;
   logic       pclk_d;
   logic       lvl_q;
   logic       lvl_d;
   logic [3:0] ph_q;
   logic [3:0] ph_d;
   logic [3:0] ph_nx;

   always_comb begin
      ph_nx  = ph_q + 4'h1;
      pclk_d = pclk_q;
      ph_d   = ph_q;
      if (lk.restart || lk.stop) begin
         pclk_d = 1'b1;
         ph_d   = 4'h0;
      end else if (lk.osc_lvl ^ osc_q) begin
         // both oscillator edges count
         ph_d = ph_nx;
         if (ph_nx == (pclk_q ? llpc_pkg::OSC_HIGH_CNT
                              : llpc_pkg::OSC_LOW_CNT)) begin
            pclk_d = ~pclk_q;
            ph_d   = 4'h0;
         end
      end
      if (lk.use_ext) begin
         lvl_d = lk.ext_lvl;
      end else if (lk.direct) begin
         lvl_d = lk.osc_lvl | lk.stop;
      end else begin
         lvl_d = pclk_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         osc_q  <= 1'b0;
         pclk_q <= 1'b1;
         lvl_q  <= 1'b1;
         ph_q   <= 4'h0;
      end else if (ce_i) begin
         osc_q  <= lk.osc_lvl;
         pclk_q <= pclk_d;
         lvl_q  <= lvl_d;
         ph_q   <= ph_d;
      end
   end

   assign lk.pclk     = lvl_q;
   assign lk.pix_rise = lvl_d & ~lvl_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   restart_high_a: assert property (
      ce_i && lk.restart && !lk.use_ext && !lk.direct |=> lk.pclk)
      else $error("pixel clock not high after restart");
endmodule : llpc_pixclk_gen

// >>> rtl/llpc_phase_det.sv
`timescale 1ns/100ps
module llpc_phase_det (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   llpc_link_if.phs  lk
);
   llpc_pkg::llpc_pd_type st_q;
   llpc_pkg::llpc_pd_type st_d;
   logic [4:0]            cnt_q;
   logic [4:0]            cnt_d;
   logic [4:0]            lim;
   logic                  pair_q;
   logic                  pair_d;
   logic                  other;

   always_comb begin
      lim     = {1'b0, lk.tol} + 5'h01;
      st_d    = st_q;
      cnt_d   = cnt_q;
      pair_d  = pair_q;
      lk.lost = 1'b0;
      lk.good = 1'b0;
      other   = (st_q == llpc_pkg::PD_REF) ? lk.cmp_edge : lk.sync_fall;
      unique case (st_q)
         llpc_pkg::PD_IDLE: begin
            cnt_d = 5'h00;
            if (lk.sync_fall && lk.cmp_edge) begin
               lk.good = 1'b1;
               pair_d  = 1'b1;
            end else if (lk.sync_fall || lk.cmp_edge) begin
               st_d   = lk.sync_fall ? llpc_pkg::PD_REF : llpc_pkg::PD_CMP;
               pair_d = 1'b0;
            end else if (lk.line_end) begin
               pair_d = 1'b0; // no sync pending at line end, pairing dropped
            end
         end
         llpc_pkg::PD_REF, llpc_pkg::PD_CMP: begin
            if (other) begin
               lk.good = 1'b1;
               pair_d  = 1'b1;
               st_d    = llpc_pkg::PD_IDLE;
            end else if (lk.line_end ||
                         (lk.pix_rise && cnt_q == lim)) begin
               lk.lost = 1'b1; // gap beyond tolerance or missing
               st_d    = llpc_pkg::PD_IDLE;
            end else if (lk.pix_rise) begin
               cnt_d = cnt_q + 5'h01;
            end
         end
         default: st_d = llpc_pkg::PD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_q   <= llpc_pkg::PD_IDLE;
         cnt_q  <= 5'h00;
         pair_q <= 1'b0;
      end else if (ce_i) begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         pair_q <= pair_d;
      end
   end

   // limiting gates adjustment to lines where both syncs were paired
   assign lk.adj_en = ~lk.limit | pair_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   limit_gate_a: assert property (
      ce_i && lk.lost |=> !lk.limit || !lk.adj_en)
      else $error("adjust allowed after unpaired line");
endmodule : llpc_phase_det

// >>> rtl/llpc_top.sv
`timescale 1ns/100ps
module llpc_top (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   input  wire logic [7:0]  host_data_i,
   output logic      [7:0]  host_data_o,
   output logic             host_data_oe_n_o,
   input  wire logic        host_rd_n_i,
   input  wire logic        host_wr_n_i,
   input  wire logic        host_a0_i,
   input  wire logic        composite_sync_n_i,
   output logic             composite_sync_n_o,
   output logic             composite_sync_oe_n_o,
   input  wire logic        frame_sync_n_i,
   input  wire logic        field_i,
   output logic             frame_sync_n_o,
   output logic             frame_sync_oe_n_o,
   input  wire logic        line_sync_gen_i,
   input  wire logic        line_sync_i,
   output logic             line_sync_o,
   output logic             line_sync_oe_n_o,
   input  wire logic        oscillator_input_a_i,
   input  wire logic        oscillator_input_a_n_i,
   input  wire logic        oscillator_input_b_i,
   input  wire logic        oscillator_input_b_n_i,
   input  wire logic        pixel_clock_i,
   output logic             pixel_clock_o,
   output logic             pixel_clock_oe_n_o,
   input  wire logic [11:0] line_length_count_i,
   output logic             capture_o,
   output logic      [1:0]  sync_slice_level_o,
   output logic             interlace_mode_o,
   output logic             phase_adjust_en_o
);
   llpc_link_if lk ();

   logic [7:0]                 cr0_q;
   logic [7:0]                 cr0_d;
   logic [7:0]                 cr1_q;
   logic [7:0]                 cr1_d;
   logic [7:0]                 cr2_q;
   logic [7:0]                 cr2_d;
   logic [4:0]                 addr_q;
   logic [4:0]                 addr_d;
   logic                       wr_q;
   logic                       rd_q;
   logic [7:0]                 rdat_q;
   logic [7:0]                 rdat_d;
   logic                       wr_fall;
   logic                       rd_rise;
   logic                       sy1_q;
   logic                       sy2_q;
   logic                       sy3_q;
   logic                       fs_q;
   logic                       hs_q;
   logic                       hs_sel;
   logic [llpc_pkg::CNT_W-1:0] cnt_q;
   logic [llpc_pkg::CNT_W-1:0] cnt_d;
   logic                       at_len;
   logic                       lls_q;
   logic                       lls_d;
   logic                       sec_q;
   logic                       sec_d;
   logic                       lck_q;
   logic                       lck_d;
   logic                       cap_q;
   logic                       cap_d;
   logic                       wr_cr1;
   logic                       restore;
   logic                       clr_st;
   logic                       vs_fall;
   llpc_pkg::llpc_mode_type    mode;
   llpc_pkg::llpc_src_type     src;

   // host port: synchronous strobes, act on write fall and read end
   always_comb begin
      wr_fall = wr_q & ~host_wr_n_i;
      rd_rise = ~rd_q & host_rd_n_i;
      cr0_d   = cr0_q;
      cr1_d   = cr1_q;
      cr2_d   = cr2_q;
      addr_d  = addr_q;
      if (wr_fall && !host_a0_i) begin
         addr_d = host_data_i[4:0];
      end else if (wr_fall) begin
         unique case (addr_q)
            llpc_pkg::ADDR_CR0: cr0_d = host_data_i;
            llpc_pkg::ADDR_CR1: cr1_d = host_data_i;
            llpc_pkg::ADDR_CR2: cr2_d = host_data_i;
            default:            cr0_d = cr0_q;
         endcase
         addr_d = addr_q + llpc_pkg::ADDR_STEP;
      end else if (rd_rise && host_a0_i) begin
         addr_d = addr_q + llpc_pkg::ADDR_STEP;
      end
      rdat_d = llpc_pkg::RD_NONE;
      if (!host_a0_i) begin
         rdat_d[4:0] = addr_q;
      end else begin
         unique case (addr_q)
            llpc_pkg::ADDR_CR0:  rdat_d = cr0_q;
            llpc_pkg::ADDR_CR1:  rdat_d = cr1_q;
            llpc_pkg::ADDR_CR2:  rdat_d = cr2_q;
            llpc_pkg::ADDR_STAT: begin
               rdat_d[llpc_pkg::STAT_LLS] = lls_q;
               rdat_d[llpc_pkg::STAT_SEC] = sec_q;
            end
            default:             rdat_d = llpc_pkg::RD_NONE;
         endcase
      end
   end

   // command registers keep no reset value: software must load them
   always_ff @(posedge ref_clk_i) begin
      if (ce_i) begin
         cr0_q <= cr0_d;
         cr1_q <= cr1_d;
         cr2_q <= cr2_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         addr_q <= 5'h00;
         wr_q   <= 1'b1;
         rd_q   <= 1'b1;
         rdat_q <= llpc_pkg::RD_NONE;
      end else if (ce_i) begin
         addr_q <= addr_d;
         wr_q   <= host_wr_n_i;
         rd_q   <= host_rd_n_i;
         rdat_q <= rdat_d;
      end
   end

   assign host_data_o      = rdat_q;
   assign host_data_oe_n_o = host_rd_n_i;

   assign mode = llpc_pkg::llpc_mode_type'(cr0_q[llpc_pkg::CR0_MODE_LO +: 2]);
   assign src  = llpc_pkg::llpc_src_type'(cr2_q[llpc_pkg::CR2_SRC_LO +: 2]);

   // oscillator source select, reserved codes give a quiet input
   always_comb begin
      unique case (cr0_q[llpc_pkg::CR0_OSC_LO +: 3])
         llpc_pkg::OSC_A:      lk.osc_lvl = oscillator_input_a_i;
         llpc_pkg::OSC_A_N:    lk.osc_lvl = oscillator_input_a_n_i;
         llpc_pkg::OSC_B:      lk.osc_lvl = oscillator_input_b_i;
         llpc_pkg::OSC_B_N:    lk.osc_lvl = oscillator_input_b_n_i;
         llpc_pkg::OSC_DIFF_A: lk.osc_lvl = oscillator_input_a_i &
                                            ~oscillator_input_a_n_i;
         llpc_pkg::OSC_DIFF_B: lk.osc_lvl = oscillator_input_b_i &
                                            ~oscillator_input_b_n_i;
         default:              lk.osc_lvl = 1'b0;
      endcase
   end

   assign lk.ext_lvl = pixel_clock_i;
   assign lk.use_ext = cr1_q[llpc_pkg::CR1_CLK_DIS] |
                       (src == llpc_pkg::SRC_EXT);
   assign lk.direct  = (src == llpc_pkg::SRC_DIRECT);
   assign lk.restart = lk.sync_fall;
   // mask is meaningless on an external clock, nothing to stop
   assign lk.stop    = at_len & ~lk.use_ext &
                       ((mode == llpc_pkg::MODE_SYNC) |
                        cr2_q[llpc_pkg::CR2_MASK]);

   llpc_pixclk_gen u_gen (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .lk        (lk.gen)
   );

   // horizontal counter
   always_comb begin
      at_len = (cnt_q == line_length_count_i);
      cnt_d  = cnt_q;
      if (lk.sync_fall && (mode == llpc_pkg::MODE_SYNC ||
                           mode == llpc_pkg::MODE_BOTH)) begin
         cnt_d = '0;
      end else if (lk.pix_rise) begin
         if (at_len && mode == llpc_pkg::MODE_SYNC) begin
            cnt_d = cnt_q;
         end else if (at_len && mode != llpc_pkg::MODE_RSV) begin
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 12'h001;
         end
      end
   end

   // lock status and capture
   always_comb begin
      wr_cr1  = wr_fall & host_a0_i & (addr_q == llpc_pkg::ADDR_CR1);
      restore = wr_cr1 & ~cr1_q[llpc_pkg::CR1_ILACE] &
                host_data_i[llpc_pkg::CR1_ILACE];
      clr_st  = wr_cr1 & ~host_data_i[llpc_pkg::CR1_LL_CLR];
      vs_fall = fs_q & ~frame_sync_n_i;
      lls_d   = lls_q;
      sec_d   = sec_q;
      if (restore) begin
         lls_d = 1'b1;
      end
      if (clr_st || lk.lost) begin
         lls_d = 1'b0; // detected loss wins
      end
      if (clr_st) begin
         sec_d = 1'b0;
      end
      lck_d = lk.good ? 1'b1 : (lk.lost ? 1'b0 : lck_q);
      cap_d = (vs_fall && field_i) ? cr0_q[llpc_pkg::CR0_CAPT] : cap_q;
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
         sy1_q <= 1'b1;
         sy2_q <= 1'b1;
         sy3_q <= 1'b1;
         fs_q  <= 1'b1;
         hs_q  <= 1'b0;
         lls_q <= llpc_pkg::LOCK_RST;
         sec_q <= llpc_pkg::LOCK_RST;
         lck_q <= llpc_pkg::LOCK_RST;
         cap_q <= 1'b0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
         sy1_q <= composite_sync_n_i;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         fs_q  <= frame_sync_n_i;
         hs_q  <= hs_sel;
         lls_q <= lls_d;
         sec_q <= sec_d;
         lck_q <= lck_d;
         cap_q <= cap_d;
      end
   end

   assign lk.sync_fall = sy3_q & ~sy2_q;
   assign hs_sel       = cr1_q[llpc_pkg::CR1_CMP_SEL] ? line_sync_gen_i
                                                      : line_sync_i;
   assign lk.cmp_edge  = hs_sel & ~hs_q;
   assign lk.line_end  = lk.pix_rise & at_len;
   assign lk.tol       = cr2_q[llpc_pkg::CR2_TOL_LO +: 4];
   assign lk.limit     = cr1_q[llpc_pkg::CR1_PLIM] &
                         (lck_q | ~cr2_q[llpc_pkg::CR2_OVR]);

   llpc_phase_det u_phs (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .lk        (lk.phs)
   );

   // sync pass-through and pin enables
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         composite_sync_n_o <= 1'b1;
         frame_sync_n_o     <= 1'b1;
         line_sync_o        <= 1'b0;
      end else if (ce_i) begin
         composite_sync_n_o <= sy2_q;
         frame_sync_n_o     <= frame_sync_n_i;
         line_sync_o        <= line_sync_gen_i;
      end
   end

   assign composite_sync_oe_n_o = cr1_q[llpc_pkg::CR1_CS_DIS];
   assign frame_sync_oe_n_o     = cr1_q[llpc_pkg::CR1_FS_DIS];
   assign line_sync_oe_n_o      = cr1_q[llpc_pkg::CR1_LS_DIS];
   assign pixel_clock_oe_n_o    = cr1_q[llpc_pkg::CR1_CLK_DIS];
   assign pixel_clock_o         = lk.pclk;
   assign sync_slice_level_o    = cr0_q[llpc_pkg::CR0_SLICE_LO +: 2];
   assign interlace_mode_o      = cr1_q[llpc_pkg::CR1_ILACE];
   assign phase_adjust_en_o     = lk.adj_en;
   assign capture_o             = cap_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   ctr_clear_a: assert property (
      ce_i && lk.sync_fall && mode inside {llpc_pkg::MODE_SYNC,
                                           llpc_pkg::MODE_BOTH}
      |=> cnt_q == '0) else $error("counter not cleared on sync");
   ctr_hold_a: assert property (
      ce_i && at_len && !lk.sync_fall && mode == llpc_pkg::MODE_SYNC
      |=> cnt_q == $past(cnt_q)) else $error("counter not held");
   ctr_wrap_a: assert property (
      ce_i && lk.pix_rise && at_len && !lk.sync_fall &&
      mode inside {llpc_pkg::MODE_BOTH, llpc_pkg::MODE_DIVN}
      |=> cnt_q == '0) else $error("counter did not wrap");
   clk_stop_a: assert property (
      ce_i && lk.stop |=> pixel_clock_o) else $error("clock not held high");
   status_clear_a: assert property (
      ce_i && clr_st |=> !lls_q && !sec_q) else $error("status not cleared");
   lock_lost_a: assert property (
      ce_i && lk.lost |=> !lls_q ##1 ($stable(lls_q) || $past(restore)))
      else $error("lock loss not flagged");
   status_set_a: assert property (
      ce_i && restore && !clr_st && !lk.lost |=> lls_q)
      else $error("status not restored");
   capture_copy_a: assert property (
      ce_i && vs_fall && field_i
      |=> capture_o == $past(cr0_q[llpc_pkg::CR0_CAPT]))
      else $error("capture pin not updated");
   relock_a: assert property (
      ce_i && lk.lost |=> lk.limit == (cr1_q[llpc_pkg::CR1_PLIM] &&
      !cr2_q[llpc_pkg::CR2_OVR])) else $error("limiting kept after loss");
   hold_cov: cover property (mode == llpc_pkg::MODE_SYNC && at_len ##1
                             lk.sync_fall);
   lost_cov: cover property (lk.lost ##[1:50] lk.good);
   capt_cov: cover property (vs_fall && field_i);
endmodule : llpc_top

// >>> sim/llpc_video_src.sv
`timescale 1ns/100ps
module llpc_video_src #(
   parameter int LINE = 50
) (
   input  wire logic ref_clk_i,
   input  wire logic sync_en_i,
   output logic      osc_o,
   output logic      osc_n_o,
   output logic      composite_sync_n_o
);
   logic osc_q = 1'b0;
   int   cnt_q = 0;
   always @(posedge ref_clk_i) begin
      osc_q <= ~osc_q;
      cnt_q <= (cnt_q == LINE - 1) ? 0 : cnt_q + 1;
   end
   assign osc_o   = osc_q;
   assign osc_n_o = ~osc_q;
   // sync tip of four cycles once a line, idle high between lines
   assign composite_sync_n_o = ~(sync_en_i && cnt_q < 4);
endmodule : llpc_video_src

// >>> sim/llpc_top_tb_top.sv
`timescale 1ns/100ps
module llpc_top_tb_top;
   logic       clk, rst, wr_n, rd_n, a0, sync_en, fs_n, fld, prev;
   logic       osc, osc_n, cs_n, oe_n, cs_o, cs_oe, fs_o, fs_oe, ls_o, ls_oe;
   logic       pclk, pclk_oe, cap, ilace, padj;
   logic [1:0] slice;
   logic [7:0] din, dout;
   logic [1:0] ls_en;
   logic       ls_pin, ls_gen;
   int         bad_count, comparisons, cycles, n;
   llpc_video_src src (.ref_clk_i(clk), .sync_en_i(sync_en), .osc_o(osc),
      .osc_n_o(osc_n), .composite_sync_n_o(cs_n));
   // external clock feeds both the clock pin and an oscillator input
   llpc_top dut (.ref_clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1),
      .host_data_i(din), .host_data_o(dout), .host_data_oe_n_o(oe_n),
      .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_a0_i(a0),
      .composite_sync_n_i(cs_n), .composite_sync_n_o(cs_o),
      .composite_sync_oe_n_o(cs_oe), .frame_sync_n_i(fs_n), .field_i(fld),
      .frame_sync_n_o(fs_o), .frame_sync_oe_n_o(fs_oe),
      .line_sync_gen_i(ls_gen), .line_sync_i(ls_pin), .line_sync_o(ls_o),
      .line_sync_oe_n_o(ls_oe), .oscillator_input_a_i(osc),
      .oscillator_input_a_n_i(osc_n), .oscillator_input_b_i(osc),
      .oscillator_input_b_n_i(osc_n), .pixel_clock_i(osc),
      .pixel_clock_o(pclk), .pixel_clock_oe_n_o(pclk_oe),
      .line_length_count_i(12'h008), .capture_o(cap),
      .sync_slice_level_o(slice), .interlace_mode_o(ilace),
      .phase_adjust_en_o(padj));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task summarize;
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic a, input logic [7:0] d);
      @(posedge clk);
      a0   <= a;
      din  <= d;
      wr_n <= 1'b0;
      repeat (2) @(posedge clk);
      wr_n <= 1'b1;
      @(posedge clk);
   endtask : wr
   task setcr(input logic [4:0] ad, input logic [7:0] d);
      wr(1'b0, {3'h0, ad});
      wr(1'b1, d);
      #1;
   endtask : setcr
   task rd(input logic [4:0] ad, input logic [7:0] m, input logic [7:0] e);
      wr(1'b0, {3'h0, ad});
      @(posedge clk);
      a0   <= 1'b1;
      rd_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(dout & m, e);
      chk({7'h00, oe_n}, 8'h00);
      @(posedge clk);
      rd_n <= 1'b1;
      @(posedge clk);
   endtask : rd
   // settle first so that the stop or restart has landed before counting
   task span;
      n = 0;
      repeat (100) @(negedge clk);
      // a stale level from the last span would count a false rise
      prev = pclk;
      repeat (200) begin
         @(negedge clk);
         if (pclk === 1'b1 && prev === 1'b0)
            n++;
         prev = pclk;
      end
   endtask : span
   // line sync pulse one edge after the sync tip, well inside tolerance
   always @(posedge clk) begin
      ls_pin <= ls_en[0] & ~cs_n;
      ls_gen <= ls_en[1] & ~cs_n;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      {rst, wr_n, rd_n, fs_n, prev} = 5'h1F;
      {a0, sync_en, fld, din} = 11'h000;
      ls_en = 2'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(5'h07, 8'h21, 8'h21);
      setcr(5'h00, 8'h58);
      wr(1'b1, 8'h84);
      wr(1'b1, 8'h34);
      rd(5'h00, 8'hFF, 8'h58);
      rd(5'h01, 8'hFF, 8'h84);
      rd(5'h02, 8'hFF, 8'h34);
      chk({cs_oe, fs_oe, ls_oe, pclk_oe, ilace}, 8'h01);
      chk({cs_o, fs_o, ls_o}, 8'h06);
      setcr(5'h01, 8'hBC);
      chk({cs_oe, fs_oe, ls_oe, pclk_oe}, 8'h0E);
      setcr(5'h03, 8'hFF);
      rd(5'h03, 8'hFF, 8'h00);
      for (int i = 0; i < 4; i++) begin
         setcr(5'h00, {3'h2, i[1:0], 3'h0});
         chk(slice, i[1:0]);
      end
      setcr(5'h01, 8'h80);
      rd(5'h07, 8'h21, 8'h00);
      setcr(5'h01, 8'h04);
      setcr(5'h01, 8'h84);
      rd(5'h07, 8'h01, 8'h01);
      setcr(5'h00, 8'h78);
      @(posedge clk);
      fld  <= 1'b1;
      fs_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(cap, 1'b1);
      chk(fs_o, 1'b0);
      setcr(5'h00, 8'h58);
      span();
      chk({n == 0, pclk}, 8'h03);
      setcr(5'h00, 8'hD8);
      span();
      chk(n > 0, 1'b1);
      setcr(5'h00, 8'hDE);
      span();
      chk(n == 0, 1'b1);
      setcr(5'h00, 8'hDC);
      span();
      chk(n > 0, 1'b1);
      setcr(5'h00, 8'h98);
      span();
      chk(n > 0, 1'b1);
      setcr(5'h02, 8'h36);
      span();
      chk(n > 75, 1'b1);
      setcr(5'h02, 8'h3C);
      span();
      chk({n == 0, pclk}, 8'h03);
      setcr(5'h02, 8'h34);
      sync_en <= 1'b1;
      setcr(5'h00, 8'h58);
      span();
      chk(n > 0, 1'b1);
      rd(5'h07, 8'h01, 8'h00);
      setcr(5'h01, 8'h85);
      chk(padj, 1'b1);
      setcr(5'h02, 8'h30);
      chk(padj, 1'b0);
      ls_en <= 2'h1;
      span();
      setcr(5'h01, 8'h05);
      setcr(5'h01, 8'h85);
      span();
      rd(5'h07, 8'h01, 8'h01);
      setcr(5'h01, 8'h87);
      span();
      rd(5'h07, 8'h01, 8'h00);
      ls_en <= 2'h2;
      span();
      setcr(5'h01, 8'h06);
      setcr(5'h01, 8'h86);
      span();
      rd(5'h07, 8'h01, 8'h01);
      setcr(5'h01, 8'hC4);
      setcr(5'h02, 8'h35);
      chk(pclk_oe, 1'b1);
      summarize();
   end
endmodule : llpc_top_tb_top
